// ==== include/sc_guard_defs.svh ====
`ifndef SC_GUARD_DEFS_SVH
`define SC_GUARD_DEFS_SVH

// Register indices; byte address is four times the index
`define IDX_BG           18'h0_fe16
`define IDX_EG           18'h0_fe17
`define IDX_SFC          18'h0_ffd4
`define IDX_ETU_CFG      18'h0_fe18
`define IDX_GUARD_STAT   18'h0_fe19
`define IDX_TX_DATA      18'h0_fe1a

`define RST_BG           8'h10
`define RST_EG           8'h0c
`define RST_SFC          8'h00
`define RST_FI_CODE      4'h1
`define RST_DI_CODE      4'h1

// Field positions
`define BG_EG_MSB_BIT    7
`define BG_COUNT_W       5
`define SFC_OVERRIDE_BIT 6
`define SFC_DISABLE_BIT  5
`define SFC_THRESH_W     3
`define CFG_T1_BIT       8
`define STAT_DEACT_BIT   16
`define STAT_LOW_BIT     17
`define STAT_TXPEND_BIT  18
`define STAT_LASTRX_BIT  19

// Least extra guard per protocol, in ETUs
`define EG_MIN_T0        9'h00c
`define EG_MIN_T1        9'h00b

// Divider used for reserved Fi/Di codes
`define ETU_DIV_FALLBACK 744

`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

`endif

// ==== include/sc_guard_pkg.sv ====
`include "sc_guard_defs.svh"

package sc_guard_pkg;

    typedef logic [12:0] etu_div_t;
    typedef etu_div_t [255:0] div_table_t;

    // Clock-rate conversion code to F, zero for reserved codes
    function automatic int f_of(input logic [3:0] code);
        case (code)
            4'h0: f_of = 372;
            4'h1: f_of = 372;
            4'h2: f_of = 558;
            4'h3: f_of = 744;
            4'h4: f_of = 1116;
            4'h5: f_of = 1488;
            4'h6: f_of = 1860;
            4'h9: f_of = 512;
            4'ha: f_of = 768;
            4'hb: f_of = 1024;
            4'hc: f_of = 1536;
            4'hd: f_of = 2048;
            default: f_of = 0;
        endcase
    endfunction : f_of

    function automatic int d_of(input logic [3:0] code);
        case (code)
            4'h1: d_of = 1;
            4'h2: d_of = 2;
            4'h3: d_of = 4;
            4'h4: d_of = 8;
            4'h8: d_of = 12;
            4'h5: d_of = 16;
            4'h9: d_of = 20;
            4'h6: d_of = 32;
            default: d_of = 0;
        endcase
    endfunction : d_of

    // Index is {fi, di}; entries are 2F/D rounded to nearest
    function automatic div_table_t build_div_table();
        div_table_t t;
        int         f;
        int         d;
        for (int i = 0; i < 256; i++) begin
            f = f_of(4'(i >> 4));
            d = d_of(4'(i));
            if (f == 0 || d == 0) begin
                t[i] = 13'(`ETU_DIV_FALLBACK);
            end else begin
                t[i] = 13'((2 * f + d / 2) / d);
            end
        end
        return t;
    endfunction : build_div_table

    localparam div_table_t DIV_TABLE = build_div_table();

    typedef struct packed {
        logic        aw_pend;
        logic [17:0] aw_idx;
        logic        w_pend;
        logic [31:0] w_data;
        logic        w_lane0;
        logic        w_lane1;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic [7:0]  bg;
        logic [7:0]  eg;
        logic [7:0]  sfc;
        logic [3:0]  fi;
        logic [3:0]  di;
        logic        t1;
        etu_div_t    etu_cnt;
        logic [8:0]  guard_cnt;
        logic        last_rx;
        logic        seen_edge;
        logic        deact;
    } guard_state_t;

endpackage : sc_guard_pkg

// ==== rtl/guard_fifo.sv ====
`timescale 1ns/1ps

module guard_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int PW = $clog2(DEPTH);

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad
        $error("guard_fifo: DEPTH must be a power of two of at least 2");
    end

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0]               rd_ptr;
        logic [PW-1:0]               wr_ptr;
        logic [PW:0]                 count;
    } fifo_state_t;

    fifo_state_t s_q;
    fifo_state_t s_d;
    logic        push;
    logic        pop;

    assign in_ready  = (s_q.count != (PW + 1)'(DEPTH));
    assign out_valid = (s_q.count != '0);
    assign out_data  = s_q.mem[s_q.rd_ptr];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        s_d = s_q;
        if (push) begin
            s_d.mem[s_q.wr_ptr] = in_data;
            s_d.wr_ptr          = s_q.wr_ptr + 1'b1;
        end
        if (pop) begin
            s_d.rd_ptr = s_q.rd_ptr + 1'b1;
        end
        s_d.count = s_q.count + (PW + 1)'(push) - (PW + 1)'(pop);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

endmodule : guard_fifo

// ==== rtl/smart_card_guard_timing.sv ====
// Functional notes
// - Clock-rate code maps to F: 0110=1860,1001=512,1010=768,1011=1024,1100=1536,1101=2048.
// - ETU divider comes from a lookup on Fi and Di codes.
// - Five-bit block guard count in ETUs, last received to first transmitted start.
// - First transmit character after a receive start waits until block guard fully elapsed; before any start edge it goes at once.
// - Nine-bit extra guard: MSB from block guard bit 7, low byte separate.
// - Transmit start edges spaced by extra guard; least 12 in T=0, 11 in T=1.
// - Enabled supply fault below threshold deactivates an active card session.
// - Fault-disable bit 5 high turns supply fault operation off.
// - Override bit 6 high uses programmed threshold code, else factory default.
// - Threshold code steps 0.1 V, 000 is 2.3 V up to 111 at 3.0 V.
`timescale 1ns/1ps

`include "sc_guard_defs.svh"

module smart_card_guard_timing #(
    parameter int         ADDR_W            = 20,
    parameter int         FIFO_DEPTH        = 4,
    parameter logic [2:0] FACTORY_THRESHOLD = 3'h0
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    output logic                   tx_char_valid,
    input  wire logic              tx_char_ready,
    output logic [7:0]             tx_char_data,
    input  wire logic              rx_start_edge,
    output logic                   etu_tick,
    input  wire logic              session_active,
    input  wire logic              supply_low,
    output logic [2:0]             supply_fault_threshold_sel,
    output logic                   card_deactivate
);
    import sc_guard_pkg::*;

    if (ADDR_W < 20 || ADDR_W > 32) begin : g_bad_addr
        $error("smart_card_guard_timing: ADDR_W must lie in 20..32");
    end

    guard_state_t s_q;
    guard_state_t s_d;

    logic       fifo_in_valid;
    logic       fifo_in_ready;
    logic       fifo_out_valid;
    logic       fifo_out_ready;
    logic [7:0] fifo_out_data;

    logic       aw_hs;
    logic       w_hs;
    logic       ar_hs;
    logic       commit;
    logic       wr_is_tx;
    logic [17:0] ar_idx;
    etu_div_t   divider;
    logic [8:0] extra_guard;
    logic [8:0] extra_min;
    logic [8:0] guard_need;
    logic       guard_ok;
    logic       tx_hs;
    logic       start_edge;
    logic       tick;
    logic       fault_enabled;

    // Transmit characters wait here for their guard slot
    guard_fifo #(
        .WIDTH (8),
        .DEPTH (FIFO_DEPTH)
    ) u_tx_fifo (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (s_q.w_data[7:0]),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data)
    );

    // Bus handshakes; up to two writes and one read in flight
    assign s_axi_awready = !s_q.aw_pend;
    assign s_axi_wready  = !s_q.w_pend;
    assign s_axi_arready = !s_q.rvalid;
    assign aw_hs         = s_axi_awvalid && !s_q.aw_pend;
    assign w_hs          = s_axi_wvalid && !s_q.w_pend;
    assign ar_hs         = s_axi_arvalid && !s_q.rvalid;
    assign ar_idx        = s_axi_araddr[19:2];

    // A full transmit buffer stalls the write response, back-pressuring software
    assign wr_is_tx      = (s_q.aw_idx == `IDX_TX_DATA);
    assign commit        = s_q.aw_pend && s_q.w_pend && !s_q.bvalid
                           && (!wr_is_tx || !s_q.w_lane0 || fifo_in_ready);
    assign fifo_in_valid = commit && wr_is_tx && s_q.w_lane0;

    assign s_axi_bvalid  = s_q.bvalid;
    assign s_axi_bresp   = s_q.bresp;
    assign s_axi_rvalid  = s_q.rvalid;
    assign s_axi_rdata   = s_q.rdata;
    assign s_axi_rresp   = s_q.rresp;

    assign divider = DIV_TABLE[{s_q.fi, s_q.di}];
    assign tick    = (s_q.etu_cnt >= divider - 13'h0001);
    assign etu_tick = tick;

    assign extra_guard = {s_q.bg[`BG_EG_MSB_BIT], s_q.eg};
    assign extra_min   = s_q.t1 ? `EG_MIN_T1 : `EG_MIN_T0;
    assign guard_need  = s_q.last_rx ? {4'h0, s_q.bg[`BG_COUNT_W-1:0]}
                       : ((extra_guard > extra_min) ? extra_guard : extra_min);
    // Until the first start edge nothing gates the slot; after it, the selected guard count holds off characters
    assign guard_ok    = !s_q.seen_edge || (s_q.guard_cnt >= guard_need);

    assign tx_char_valid  = fifo_out_valid && guard_ok;
    assign tx_char_data   = fifo_out_data;
    assign tx_hs          = tx_char_valid && tx_char_ready;
    assign fifo_out_ready = tx_char_ready && guard_ok;
    assign start_edge     = tx_hs || rx_start_edge;

    assign fault_enabled  = !s_q.sfc[`SFC_DISABLE_BIT];
    // Factory value stands until software takes over by setting override bit 6, which reset clears
    assign supply_fault_threshold_sel = s_q.sfc[`SFC_OVERRIDE_BIT]
                                      ? s_q.sfc[`SFC_THRESH_W-1:0]
                                      : FACTORY_THRESHOLD;
    assign card_deactivate = s_q.deact;

    always_comb begin
        s_d = s_q;

        // Write address and data, in either order
        if (aw_hs) begin
            s_d.aw_pend = 1'b1;
            s_d.aw_idx  = s_axi_awaddr[19:2];
        end
        if (w_hs) begin
            s_d.w_pend  = 1'b1;
            s_d.w_data  = s_axi_wdata;
            s_d.w_lane0 = s_axi_wstrb[0];
            s_d.w_lane1 = s_axi_wstrb[1];
        end
        if (s_q.bvalid && s_axi_bready) begin
            s_d.bvalid = 1'b0;
        end
        if (commit) begin
            s_d.aw_pend = 1'b0;
            s_d.w_pend  = 1'b0;
            s_d.bvalid  = 1'b1;
            s_d.bresp   = `RESP_OKAY;
            case (s_q.aw_idx)
                `IDX_BG: begin
                    if (s_q.w_lane0) begin
                        s_d.bg = s_q.w_data[7:0];
                    end
                end
                `IDX_EG: begin
                    if (s_q.w_lane0) begin
                        s_d.eg = s_q.w_data[7:0];
                    end
                end
                `IDX_SFC: begin
                    if (s_q.w_lane0) begin
                        s_d.sfc = s_q.w_data[7:0];
                    end
                end
                `IDX_ETU_CFG: begin
                    if (s_q.w_lane0) begin
                        s_d.fi = s_q.w_data[3:0];
                        s_d.di = s_q.w_data[7:4];
                    end
                    // Lane 1 carries the protocol bit
                    if (s_q.w_lane1) begin
                        s_d.t1 = s_q.w_data[`CFG_T1_BIT];
                    end
                end
                `IDX_TX_DATA, `IDX_GUARD_STAT: begin
                end
                default: begin
                    s_d.bresp = `RESP_SLVERR;
                end
            endcase
        end

        // Reads answer one cycle after the address is taken
        if (s_q.rvalid && s_axi_rready) begin
            s_d.rvalid = 1'b0;
        end
        if (ar_hs) begin
            s_d.rvalid = 1'b1;
            s_d.rresp  = `RESP_OKAY;
            s_d.rdata  = 32'h0000_0000;
            case (ar_idx)
                `IDX_BG:      s_d.rdata[7:0] = s_q.bg;
                `IDX_EG:      s_d.rdata[7:0] = s_q.eg;
                `IDX_SFC:     s_d.rdata[7:0] = s_q.sfc;
                `IDX_ETU_CFG: s_d.rdata[8:0] = {s_q.t1, s_q.di, s_q.fi};
                `IDX_GUARD_STAT: begin
                    s_d.rdata[12:0]             = divider;
                    s_d.rdata[`STAT_DEACT_BIT]  = s_q.deact;
                    s_d.rdata[`STAT_LOW_BIT]    = supply_low;
                    s_d.rdata[`STAT_TXPEND_BIT] = fifo_out_valid;
                    s_d.rdata[`STAT_LASTRX_BIT] = s_q.last_rx;
                    s_d.rdata[28:20]            = s_q.guard_cnt;
                end
                `IDX_TX_DATA: begin
                end
                default: begin
                    s_d.rresp = `RESP_SLVERR;
                end
            endcase
        end

        // ETU and guard counting; a start edge realigns both
        if (start_edge) begin
            s_d.etu_cnt   = '0;
            s_d.guard_cnt = '0;
            s_d.seen_edge = 1'b1;
            // A receive edge in the same cycle wins: the block guard count then gates the next character
            s_d.last_rx   = rx_start_edge;
        end else if (tick) begin
            s_d.etu_cnt = '0;
            if (s_q.guard_cnt != 9'h1ff) begin
                s_d.guard_cnt = s_q.guard_cnt + 9'h001;
            end
        end else begin
            s_d.etu_cnt = s_q.etu_cnt + 13'h0001;
        end

        s_d.deact = fault_enabled && supply_low && session_active;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q     <= '0;
            s_q.bg  <= `RST_BG;
            s_q.eg  <= `RST_EG;
            s_q.sfc <= `RST_SFC;
            s_q.fi  <= `RST_FI_CODE;
            s_q.di  <= `RST_DI_CODE;
        end else begin
            s_q <= s_d;
        end
    end

endmodule : smart_card_guard_timing

// ==== testbench/smart_card_guard_timing_chk.sv ====
`timescale 1ns/1ps

module smart_card_guard_timing_chk (
    input wire logic       aclk,
    input wire logic       aresetn,
    input wire logic       s_axi_awvalid,
    input wire logic       s_axi_awready,
    input wire logic       s_axi_bvalid,
    input wire logic       s_axi_bready,
    input wire logic       s_axi_arvalid,
    input wire logic       s_axi_arready,
    input wire logic       s_axi_rvalid,
    input wire logic       s_axi_rready,
    input wire logic       tx_char_valid,
    input wire logic       tx_char_ready,
    input wire logic [7:0] tx_char_data,
    input wire logic       etu_tick,
    input wire logic       session_active,
    input wire logic       supply_low,
    input wire logic       card_deactivate
);
    logic [7:0] gap_q;
    logic [7:0] gap_d;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence tx_take;
        tx_char_valid && tx_char_ready;
    endsequence
    sequence ar_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence fault_seen;
        ($past(supply_low) || $past(supply_low, 2))
            && ($past(session_active) || $past(session_active, 2));
    endsequence
    // Saturates so a long idle never reads as a short gap
    always_comb begin
        gap_d = gap_q;
        if (tx_char_valid && tx_char_ready) begin
            gap_d = 8'h00;
        end else if (etu_tick && gap_q != 8'hff) begin
            gap_d = gap_q + 8'h01;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            gap_q <= 8'hff;
        end else begin
            gap_q <= gap_d;
        end
    end
    // One tick of slack for divider phase at the start edge
    a_tx_gap_min: assert property (tx_take |-> gap_q >= 8'h0a)
        else $error("tx characters too close");
    a_tick_one_cycle: assert property (etu_tick |=> !etu_tick)
        else $error("etu tick too long");
    a_tx_char_hold: assert property (tx_char_valid && !tx_char_ready
        |=> tx_char_valid && $stable(tx_char_data))
        else $error("tx char dropped or changed");
    a_deact_cause: assert property ($rose(card_deactivate) |-> fault_seen)
        else $error("deactivate without supply fault");
    a_read_answer: assert property (ar_take |-> ##[1:32] s_axi_rvalid)
        else $error("read not answered");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready |-> ##[0:32] s_axi_bvalid)
        else $error("write not answered");
    a_b_clears: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    a_r_clears: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read response repeated");
endmodule : smart_card_guard_timing_chk

// ==== testbench/card_model.sv ====
`timescale 1ns/1ps

module card_model (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       tx_char_valid,
    output logic            tx_char_ready,
    input  wire logic [7:0] tx_char_data,
    output logic            rx_start_edge,
    input  wire logic       slow
);
    int unsigned cyc;
    int unsigned acc_t[$];
    logic [7:0]  acc_d[$];
    logic        ph;
    initial begin
        tx_char_ready = 1'b0;
        rx_start_edge = 1'b0;
        ph = 1'b0;
        cyc = 0;
    end
    // A busy card takes a character only every other cycle
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        ph <= ~ph;
        tx_char_ready <= aresetn && (!slow || ph);
        if (tx_char_valid && tx_char_ready) begin
            acc_t.push_back(cyc);
            acc_d.push_back(tx_char_data);
        end
    end
    task automatic send_start();
        @(posedge aclk);
        rx_start_edge <= 1'b1;
        @(posedge aclk);
        rx_start_edge <= 1'b0;
    endtask : send_start
endmodule : card_model

// ==== testbench/smart_card_guard_timing_bench.sv ====
`timescale 1ns/1ps
`include "sc_guard_defs.svh"

module smart_card_guard_timing_bench;
    localparam logic [19:0] A_BG  = {`IDX_BG, 2'b00};
    localparam logic [19:0] A_EG  = {`IDX_EG, 2'b00};
    localparam logic [19:0] A_SFC = {`IDX_SFC, 2'b00};
    localparam logic [19:0] A_CFG = {`IDX_ETU_CFG, 2'b00};
    localparam logic [19:0] A_TXD = {`IDX_TX_DATA, 2'b00};
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid, txv, txr, rxe, tick;
    logic        sess, low, deact, slow;
    logic [19:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0]  bresp, rresp;
    logic [7:0]  txd;
    logic [2:0]  thr;
    int          failures;
    int          checks;
    smart_card_guard_timing #(.FACTORY_THRESHOLD(3'h4)) i_smart_card_guard_timing (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .tx_char_valid(txv), .tx_char_ready(txr), .tx_char_data(txd),
        .rx_start_edge(rxe), .etu_tick(tick), .session_active(sess), .supply_low(low),
        .supply_fault_threshold_sel(thr), .card_deactivate(deact));
    card_model i_card_model (.aclk(aclk), .aresetn(aresetn), .tx_char_valid(txv),
        .tx_char_ready(txr), .tx_char_data(txd), .rx_start_edge(rxe), .slow(slow));
    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end
    task automatic close_out();
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : close_out
    task automatic hang();
        failures++;
        $display("TIMEOUT at %0t", $time);
        close_out();
    endtask : hang
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [19:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (n < 200) begin
            @(posedge aclk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) begin
                chk(32'(bresp), 32'(er));
                bready <= 1'b0;
                return;
            end
        end
        hang();
    endtask : wr
    task automatic rd(input logic [19:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (n < 200) begin
            @(posedge aclk);
            n++;
            if (arready) arvalid <= 1'b0;
            if (rvalid) begin
                chk(32'(rresp), 32'(er));
                if (er === `RESP_OKAY) chk(rdata, ed);
                rready <= 1'b0;
                return;
            end
        end
        hang();
    endtask : rd
    task automatic t_regs();
        rd(A_BG, 32'h0000_0010, `RESP_OKAY);
        rd(A_EG, 32'h0000_000c, `RESP_OKAY);
        rd(A_SFC, 32'h0000_0000, `RESP_OKAY);
        wr(A_BG, 32'h0000_0095, `RESP_OKAY);
        rd(A_BG, 32'h0000_0095, `RESP_OKAY);
        wr(20'h0_0010, 32'h0000_00ff, `RESP_SLVERR);
        rd(20'h0_0010, 32'h0000_0000, `RESP_SLVERR);
        $display("registers done");
    endtask : t_regs
    task automatic t_fault();
        logic seen;
        int   n;
        seen = 1'b0;
        n = 0;
        wr(A_SFC, 32'h0000_0020, `RESP_OKAY);
        sess <= 1'b1;
        low <= 1'b1;
        repeat (40) begin
            @(posedge aclk);
            seen = seen | deact;
        end
        chk(32'(seen), 32'h0000_0000);
        wr(A_SFC, 32'h0000_0000, `RESP_OKAY);
        while (deact !== 1'b1) begin
            @(posedge aclk);
            n++;
            if (n > 40) hang();
        end
        chk(32'(deact), 32'h0000_0001);
        sess <= 1'b0;
        low <= 1'b0;
        for (int c = 0; c < 8; c++) begin
            wr(A_SFC, 32'h0000_0040 | 32'(c), `RESP_OKAY);
            repeat (2) @(posedge aclk);
            chk(32'(thr), 32'(c));
        end
        wr(A_SFC, 32'h0000_0005, `RESP_OKAY);
        repeat (2) @(posedge aclk);
        chk(32'(thr), 32'h0000_0004);
        $display("supply fault done");
    endtask : t_fault
    task automatic t_etu();
        logic [7:0] cfg[9] = '{8'h11, 8'h16, 8'h19, 8'h1a, 8'h4b, 8'h8c, 8'h9d, 8'h86, 8'h69};
        int         div[9] = '{744, 3720, 1024, 1536, 256, 256, 205, 310, 32};
        int         p;
        for (int k = 0; k < 9; k++) begin
            wr(A_CFG, 32'(cfg[k]), `RESP_OKAY);
            for (int r = 0; r < 2; r++) begin
                p = 0;
                do begin
                    @(posedge aclk);
                    p++;
                end while (tick !== 1'b1 && p < 8000);
                if (p >= 8000) hang();
            end
            chk(32'(p), 32'(div[k]));
        end
        $display("etu divider done");
    endtask : t_etu
    task automatic t_guard();
        logic [31:0] bg[3] = '{32'h0000_0010, 32'h0000_0010, 32'h0000_0090};
        logic [31:0] eg[3] = '{32'h0000_0003, 32'h0000_0003, 32'h0000_0000};
        logic [31:0] cf[3] = '{32'h0000_0069, 32'h0000_0169, 32'h0000_0069};
        int          sp[3] = '{12, 11, 256};
        int          t0;
        int          b;
        int          n;
        int          g;
        for (int k = 0; k < 3; k++) begin
            b = 3 * k;
            n = 0;
            slow <= (k == 2);
            wr(A_CFG, cf[k], `RESP_OKAY);
            wr(A_BG, bg[k], `RESP_OKAY);
            wr(A_EG, eg[k], `RESP_OKAY);
            i_card_model.send_start();
            t0 = int'(i_card_model.cyc);
            wr(A_TXD, 32'h0000_00a5, `RESP_OKAY);
            wr(A_TXD, 32'h0000_003c, `RESP_OKAY);
            wr(A_TXD, 32'h0000_0069, `RESP_OKAY);
            while (i_card_model.acc_t.size() < b + 3) begin
                @(posedge aclk);
                n++;
                if (n > 30000) hang();
            end
            g = int'(i_card_model.acc_t[b]) - t0;
            chk(32'(g >= 15 * 32 && g <= 19 * 32), 32'h0000_0001);
            for (int i = 0; i < 2; i++) begin
                g = int'(i_card_model.acc_t[b + i + 1] - i_card_model.acc_t[b + i]);
                chk(32'(g >= (sp[k] - 1) * 32 && g <= (sp[k] + 2) * 32), 32'h0000_0001);
            end
            chk(32'(i_card_model.acc_d[b]), 32'h0000_00a5);
            chk(32'(i_card_model.acc_d[b + 2]), 32'h0000_0069);
        end
        $display("guard timing done");
    endtask : t_guard
    initial begin
        failures = 0;
        checks = 0;
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        awaddr = 20'h0_0000;
        araddr = 20'h0_0000;
        wdata = 32'h0000_0000;
        {sess, low, slow} = 3'h0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_fault();
        t_etu();
        t_guard();
        close_out();
    end
endmodule : smart_card_guard_timing_bench

bind smart_card_guard_timing smart_card_guard_timing_chk i_smart_card_guard_timing_chk (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .tx_char_valid,
    .tx_char_ready, .tx_char_data, .etu_tick, .session_active, .supply_low,
    .card_deactivate);
